// ===== dv/ir_fifo_model.sv
module ir_fifo_model (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // bench load port
    input  wire logic              i_load,
    input  wire ir_pkg::rx_entry_s i_entry,
    // host side
    input  wire logic              i_pop,
    input  wire logic              i_tx_push,
    input  wire logic              i_fifo_en,
    output ir_pkg::rx_entry_s      o_head,
    output logic                   o_empty,
    output logic                   o_err,
    output logic                   o_txf_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    ir_pkg::rx_entry_s q[$];
    ir_pkg::rx_entry_s gone;
    int                tx_cnt;
    logic              e;

    // outputs move by nba so the host never races the update
    always @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            q.delete();
            tx_cnt = 0;
            gone = '0;
        end
        else
        begin
            if (i_pop && q.size() > 0)
                gone = q.pop_front();
            if (i_load)
                q.push_back(i_entry);
            // holding register loads outside fifo mode never enter the fifo
            if (i_tx_push && i_fifo_en)
                tx_cnt++;
        end
        e = 1'b0;
        foreach (q[k])
            e = e | q[k].fe | q[k].pe | q[k].brk;
        // empty head shows no stale byte
        o_head <= (q.size() == 0) ? ~gone : q[0];
        o_empty <= (q.size() == 0);
        o_err <= e;
        o_txf_empty <= (tx_cnt == 0);
    end
endmodule

// ===== dv/tb_ir_host_regs.sv
module tb_ir_host_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 50;
    logic              clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, serial_input = 1;
    logic [7:0]        adr = 0, d, d1;
    logic [3:0]        sel = 0, low;
    logic [31:0]       wdat = 0, rdat;
    logic              cts_n = 0, dsr_n = 0, ri_n = 0, dcd_n = 1;
    logic              at_th = 0, below = 0, thr_e = 1, sh_e = 1, samp = 0;
    logic              tc = 0, fend = 0, fstart = 0, load = 0;
    logic              ack, pop, push, brk_push, irq, rx_empty, rx_err, txf_empty, fifo_en;
    logic [7:0]        txd;
    logic [15:0]       divisor;
    logic [8:0]        e;
    ir_pkg::rx_entry_s ent = '0, head;
    ir_pkg::mode_e     mode;
    int                fail_count = 0, samples_checked = 0, brk_cnt = 0;
    integer            seed = 32'h8ef213e1;
    logic [8:0]        rd_q[$];
    logic [7:0]        tx_q[$];

    always #2.5 clk = ~clk;

    ir_host_regs #(.GAP_CYCLES(GAP)) u_ir_host_regs (
        .i_mclk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_serial_input(serial_input), .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_ri_n(ri_n),
        .i_dcd_n(dcd_n), .i_rx_head(head), .i_rx_empty(rx_empty), .i_rx_err_present(rx_err),
        .i_rx_at_thresh(at_th), .i_tx_below_thresh(below), .i_txf_empty(txf_empty),
        .i_thr_empty(thr_e), .i_tx_xfer(1'b0), .i_shift_empty(sh_e), .i_rx_sample(samp),
        .i_lsr_low(low), .i_rx_overrun(1'b0), .i_tx_underrun(1'b0), .i_rx_eof(1'b0),
        .i_stat_at_thresh(1'b0), .i_dma_tc(tc), .i_frame_start(fstart), .i_frame_end(fend),
        .o_rx_pop(pop), .o_tx_push(push), .o_tx_data(txd), .o_brk_push(brk_push),
        .o_brk_entry(), .o_rx_enable(), .o_divisor(divisor), .o_line_ctrl(), .o_mode(mode),
        .o_fifo_en(fifo_en), .o_irq(irq));

    ir_fifo_model u_ir_fifo_model (
        .i_clk(clk), .i_rst_b(rst_b), .i_load(load), .i_entry(ent), .i_pop(pop),
        .i_tx_push(push), .i_fifo_en(fifo_en), .o_head(head), .o_empty(rx_empty), .o_err(rx_err),
        .o_txf_empty(txf_empty));

    task automatic chk_val(input string nm, input logic [15:0] x, input logic [15:0] g);
        samples_checked++;
        if (g !== x)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
            fail_count++;
        end
    endtask

    task automatic chk_bit(input string nm, input logic x, input logic g);
        samples_checked++;
        if (g !== x)
        begin
            $display("CHECK FAILED %s expected %b seen %b", nm, x, g);
            fail_count++;
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // waits for ack with no assumed latency; one idle cycle follows
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] dv);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= {24'h0, dv};
        @(posedge clk);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
            fail_count++;
        cyc <= 0;
        stb <= 0;
    endtask

    // bit 8 of a note marks a read whose value is not judged
    task automatic rd(input logic [7:0] a, input logic [8:0] x);
        rd_q.push_back(x);
        wb(1'b0, a, 8'h00);
    endtask

    task automatic irq_is(input logic x);
        repeat (2) @(posedge clk);
        chk_bit("irq", x, irq);
    endtask

    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0)
        begin
            e = rd_q.pop_front();
            if (!e[8])
                chk_val("read data", {8'h00, e[7:0]}, rdat[15:0]);
        end
        // holding register pushes in the uart mode are not fifo traffic
        if (push === 1'b1 && mode != ir_pkg::MODE_SIR)
            chk_val("tx byte", {8'h00, tx_q.pop_front()}, {8'h00, txd});
        if (brk_push === 1'b1)
            brk_cnt++;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        close_out();
    end

    initial
    begin
        low = $random(seed);
        repeat (12) @(posedge clk);
        rst_b <= 1;
        rd(8'h04, 9'h000);
        rd(8'h10, 9'h000);
        d = $random(seed);
        wb(1, 8'h1C, d);
        rd(8'h1C, {1'b0, d});
        rd(8'h18, 9'h100);
        rd(8'h18, 9'h070);
        cts_n <= 1;
        dsr_n <= 1;
        ri_n <= 1;
        repeat (4) @(posedge clk);
        rd(8'h18, 9'h007);
        rd(8'h14, {5'b00110, low});
        // long low line well past one character of samples
        serial_input <= 0;
        repeat (400) @(posedge clk) samp <= ~samp;
        serial_input <= 1;
        repeat (40) @(posedge clk) samp <= ~samp;
        samp <= 0;
        chk_bit("break pushes", 1'b1, brk_cnt == 1);
        rd(8'h14, {5'b00111, low});
        rd(8'h14, {5'b00110, low});
        wb(1, 8'h04, 8'h02);
        irq_is(1);
        thr_e <= 0;
        wb(1, 8'h00, d);
        rd(8'h14, {5'b00000, low});
        irq_is(0);
        thr_e <= 1;
        d1 = $random(seed);
        wb(1, 8'h0C, 8'h80);
        wb(1, 8'h00, d);
        wb(1, 8'h04, d1);
        chk_val("divisor", {d1, d}, divisor);
        rd(8'h00, {1'b0, d});
        rd(8'h04, 9'h000);
        wb(1, 8'h0C, 8'h00);
        rd(8'h04, 9'h002);
        wb(1, 8'h20, 8'h05);
        wb(1, 8'h04, 8'hFF);
        rd(8'h04, 9'h0AF);
        wb(1, 8'h04, 8'h04);
        ent <= {1'b1, 1'b0, 1'b1, 1'b0, d1};
        load <= 1;
        @(posedge clk);
        load <= 0;
        repeat (2) @(posedge clk);
        rd(8'h14, {5'b01110, low});
        rd(8'h00, {1'b0, d1});
        irq_is(1);
        rd(8'h08, 9'h100);
        irq_is(0);
        tx_q.push_back(d);
        wb(1, 8'h00, d);
        for (int k = 0; k < 2; k++)
        begin
            wb(1, 8'h04, 8'h01 << k);
            {below, at_th} <= 2'b01 << k;
            irq_is(1);
            {below, at_th} <= 2'b00;
            irq_is(0);
        end
        wb(1, 8'h20, 8'h02);
        wb(1, 8'h04, 8'hFF);
        rd(8'h04, 9'h074);
        wb(1, 8'h04, 8'h40);
        tc <= 1;
        @(posedge clk);
        tc <= 0;
        irq_is(1);
        rd(8'h08, 9'h040);
        irq_is(0);
        fstart <= 1;
        @(posedge clk);
        fstart <= 0;
        rd(8'h08, 9'h100);
        wb(1, 8'h04, 8'h04);
        fend <= 1;
        @(posedge clk);
        fend <= 0;
        repeat (38) @(posedge clk);
        chk_bit("gap irq early", 1'b0, irq);
        repeat (20) @(posedge clk);
        chk_bit("gap irq", 1'b1, irq);
        close_out();
    end
endmodule

// ===== hw/ir_host_regs.sv
// Notes on behaviour
// - break flag after low line, read clears
// - one zero char, resume after marks
// - fifo break shown at fifo head
// - holding empty drops on load, or on transfer outside fifo mode
// - holding empty interrupt when enabled, in sir mode only
// - fifo holding empty until byte written
// - transmitter empty needs holding and shifter empty
// - receive fifo error flag, zero if disabled
// - modem deltas and ring trailing edge
// - modem bits 4-7 complement inputs
// - scratch byte at address seven
// - divisor access writes both divisor bytes, reads back the low byte only
// - data read pops receive fifo
// - data write pushes transmit fifo
// - enable register at one, resets zero
// - enable 0: receive at threshold
// - enable 1: transmit below threshold
// - enable 2: last frame byte read
// - enables 3,5,7 overrun, underrun, end-of-frame
// - dma enable 2: gap timeout 1ms
// - dma enables 4,5 status threshold, underrun
// - dma enable 6: terminal count
// - divisor select picks shared addresses
`include "ir_params.svh"

module ir_host_regs #(
    parameter int GAP_CYCLES = `GAP_CYCLES
) (
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    // wishbone slave
    input  wire logic              i_wb_cyc,
    input  wire logic              i_wb_stb,
    input  wire logic              i_wb_we,
    input  wire logic [7:0]        i_wb_adr,
    input  wire logic [3:0]        i_wb_sel,
    input  wire logic [31:0]       i_wb_dat,
    output logic      [31:0]       o_wb_dat,
    output logic                   o_wb_ack,
    // pins, asynchronous
    input  wire logic              i_serial_input,
    input  wire logic              i_cts_n,
    input  wire logic              i_dsr_n,
    input  wire logic              i_ri_n,
    input  wire logic              i_dcd_n,
    // datapath status
    input  wire ir_pkg::rx_entry_s i_rx_head,
    input  wire logic              i_rx_empty,
    input  wire logic              i_rx_err_present,
    input  wire logic              i_rx_at_thresh,
    input  wire logic              i_tx_below_thresh,
    input  wire logic              i_txf_empty,
    input  wire logic              i_thr_empty,
    input  wire logic              i_tx_xfer,
    input  wire logic              i_shift_empty,
    input  wire logic              i_rx_sample,
    input  wire logic [3:0]        i_lsr_low,
    // datapath events
    input  wire logic              i_rx_overrun,
    input  wire logic              i_tx_underrun,
    input  wire logic              i_rx_eof,
    input  wire logic              i_stat_at_thresh,
    input  wire logic              i_dma_tc,
    input  wire logic              i_frame_start,
    input  wire logic              i_frame_end,
    // datapath control
    output logic                   o_rx_pop,
    output logic                   o_tx_push,
    output logic      [7:0]        o_tx_data,
    output logic                   o_brk_push,
    output ir_pkg::rx_entry_s      o_brk_entry,
    output logic                   o_rx_enable,
    output logic      [15:0]       o_divisor,
    output logic      [7:0]        o_line_ctrl,
    output ir_pkg::mode_e          o_mode,
    output logic                   o_fifo_en,
    output logic                   o_irq
);

    // character time in 16x samples: start, data, parity, and only the extra stop bit of lcr[2]
    function automatic logic [7:0] char_ticks(input logic [7:0] lcr);
        logic [3:0] bits;
        bits = 4'h6 + {2'h0, lcr[1:0]} + {3'h0, lcr[3]} + {3'h0, lcr[2]};
        return {bits, 4'h0};
    endfunction

    function automatic logic hit(input logic [5:0] idx, input logic [5:0] want);
        return idx == want;
    endfunction

    logic              ack_q;
    logic              acc;
    logic              wr;
    logic              rd;
    logic [5:0]        idx;
    logic              dlab;
    logic [7:0]        wbyte;
    logic [7:0]        lcr_q;
    logic [7:0]        ier_q;
    logic [7:0]        scr_q;
    logic [7:0]        dll_q;
    logic [7:0]        dlm_q;
    ir_pkg::mode_e     mode_q;
    logic              fifo_q;
    logic [4:0]        sync1_q;
    logic [4:0]        sync2_q;
    logic [4:0]        prev_q;
    logic [3:0]        delta_q;
    logic              brk_q;
    logic              ferr_q;
    logic              he_q;
    ir_pkg::brk_state_e bst_q;
    logic [7:0]        low_cnt_q;
    logic [1:0]        mark_cnt_q;
    logic [7:0]        pend_q;
    logic [17:0]       gap_cnt_q;
    logic              gap_run_q;
    logic [7:0]        level;
    logic [7:0]        pend_all;
    logic [7:0]        serial_line_status;
    logic [7:0]        handshake_status;
    logic [7:0]        ier_mask;
    logic              lsr_rd;
    logic              msr_rd;
    logic              pend_rd;
    logic              data_rd;
    logic              data_wr;
    logic              serial_input;
    logic              brk_event;

    assign acc     = i_wb_cyc & i_wb_stb & ~ack_q;
    assign wr      = acc & i_wb_we & i_wb_sel[0];
    assign rd      = acc & ~i_wb_we;
    assign idx     = i_wb_adr[7:2];
    assign wbyte   = i_wb_dat[7:0];
    assign dlab    = lcr_q[`LCR_DLAB];
    assign lsr_rd  = rd & hit(idx, `IDX_LSR);
    assign msr_rd  = rd & hit(idx, `IDX_MSR);
    assign pend_rd = rd & hit(idx, `IDX_PEND);
    assign data_rd = rd & hit(idx, `IDX_DATA) & ~dlab;
    assign data_wr = wr & hit(idx, `IDX_DATA) & ~dlab;
    assign serial_input     = sync2_q[4];

    // wishbone: ack one cycle after the strobe, effects taken at that edge
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
            ack_q <= 1'b0;
        else
            ack_q <= acc;
    end
    assign o_wb_ack = ack_q;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
            o_wb_dat <= 32'h0000_0000;
        else if (rd)
        begin
            case (idx)
                `IDX_DATA: o_wb_dat <= {24'h00_0000, dlab ? dll_q : i_rx_head.data};
                `IDX_IER:  o_wb_dat <= {24'h00_0000, dlab ? 8'h00 : ier_q};
                `IDX_PEND: o_wb_dat <= {24'h00_0000, pend_all};
                `IDX_LCR:  o_wb_dat <= {24'h00_0000, lcr_q};
                `IDX_LSR:  o_wb_dat <= {24'h00_0000, serial_line_status};
                `IDX_MSR:  o_wb_dat <= {24'h00_0000, handshake_status};
                `IDX_SCR:  o_wb_dat <= {24'h00_0000, scr_q};
                `IDX_MODE: o_wb_dat <= {24'h00_0000, 5'h00, fifo_q, mode_q};
                default:   o_wb_dat <= 32'h0000_0000;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            lcr_q  <= `RESET_BYTE;
            scr_q  <= `RESET_BYTE;
            dll_q  <= `RESET_BYTE;
            dlm_q  <= `RESET_BYTE;
            mode_q <= ir_pkg::MODE_SIR;
            fifo_q <= 1'b0;
        end
        else if (wr)
        begin
            if (hit(idx, `IDX_LCR))
                lcr_q <= wbyte;
            if (hit(idx, `IDX_SCR))
                scr_q <= wbyte;
            if (hit(idx, `IDX_DATA) && dlab)
                dll_q <= wbyte;
            if (hit(idx, `IDX_IER) && dlab)
                dlm_q <= wbyte;
            if (hit(idx, `IDX_MODE))
            begin
                mode_q <= (wbyte[1:0] == 2'h3) ? ir_pkg::MODE_SIR : ir_pkg::mode_e'(wbyte[1:0]);
                fifo_q <= wbyte[`MODE_FIFO];
            end
        end
    end

    // write-zero bits are held at zero whatever software writes
    always_comb
    begin
        case (mode_q)
            ir_pkg::MODE_PIO: ier_mask = `IER_MASK_PIO;
            ir_pkg::MODE_DMA: ier_mask = `IER_MASK_DMA;
            default:          ier_mask = `IER_MASK_SIR;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
            ier_q <= `RESET_BYTE;
        else if (wr && hit(idx, `IDX_IER) && !dlab)
            ier_q <= wbyte & ier_mask;
        else
            ier_q <= ier_q & ier_mask;
    end

    // fifo port strobes, registered
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            o_rx_pop  <= 1'b0;
            o_tx_push <= 1'b0;
            o_tx_data <= `RESET_BYTE;
        end
        else
        begin
            o_rx_pop  <= data_rd & ~i_rx_empty;
            o_tx_push <= data_wr;
            if (data_wr)
                o_tx_data <= wbyte;
        end
    end

    // pin synchronisers
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            sync1_q <= 5'h1F;
            sync2_q <= 5'h1F;
            prev_q  <= 5'h1F;
        end
        else
        begin
            sync1_q <= {i_serial_input, i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // modem deltas: set wins over the read that clears
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
            delta_q <= 4'h0;
        else
        begin
            delta_q[0] <= (sync2_q[0] ^ prev_q[0]) | (delta_q[0] & ~msr_rd);
            delta_q[1] <= (sync2_q[1] ^ prev_q[1]) | (delta_q[1] & ~msr_rd);
            delta_q[2] <= (sync2_q[2] & ~prev_q[2]) | (delta_q[2] & ~msr_rd);
            delta_q[3] <= (sync2_q[3] ^ prev_q[3]) | (delta_q[3] & ~msr_rd);
        end
    end
    assign handshake_status = {~sync2_q[3:0], delta_q};

    // break detector on the 16x sample strobe
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            bst_q      <= ir_pkg::BRK_HUNT;
            low_cnt_q  <= 8'h00;
            mark_cnt_q <= 2'h0;
        end
        else if (i_rx_sample)
        begin
            case (bst_q)
                ir_pkg::BRK_HUNT:
                begin
                    low_cnt_q <= serial_input ? 8'h00 : low_cnt_q + 8'h01;
                    if (brk_event)
                        bst_q <= ir_pkg::BRK_HELD;
                end
                ir_pkg::BRK_HELD:
                begin
                    mark_cnt_q <= 2'h0;
                    if (serial_input)
                        bst_q <= ir_pkg::BRK_MARK;
                end
                ir_pkg::BRK_MARK:
                begin
                    mark_cnt_q <= serial_input ? mark_cnt_q + 2'h1 : 2'h0;
                    if (serial_input && mark_cnt_q + 2'h1 >= `MARK_SAMPLES)
                        bst_q <= ir_pkg::BRK_START;
                end
                ir_pkg::BRK_START:
                begin
                    low_cnt_q <= 8'h00;
                    if (!serial_input)
                        bst_q <= ir_pkg::BRK_HUNT;
                end
                default: bst_q <= ir_pkg::BRK_HUNT;
            endcase
        end
    end
    assign brk_event   = i_rx_sample & (bst_q == ir_pkg::BRK_HUNT) & ~serial_input
                         & (low_cnt_q + 8'h01 >= char_ticks(lcr_q));
    // receiver held off until marks then a fresh start bit
    assign o_rx_enable = (bst_q == ir_pkg::BRK_HUNT);

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            o_brk_push  <= 1'b0;
            o_brk_entry <= '0;
        end
        else
        begin
            o_brk_push  <= brk_event;
            o_brk_entry <= '{last: 1'b0, brk: 1'b1, fe: 1'b0, pe: 1'b0, data: 8'h00};
        end
    end

    // non-fifo break flag; in fifo mode the tag rides with the character
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
            brk_q <= 1'b0;
        else
            brk_q <= (brk_event & ~fifo_q) | (brk_q & ~lsr_rd);
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
            ferr_q <= 1'b0;
        else
            ferr_q <= fifo_q & (i_rx_err_present | (ferr_q & ~lsr_rd));
    end

    // holding empty, also dropped in the cycle of a load, or of a transfer outside fifo mode
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
            he_q <= 1'b1;
        else if (fifo_q)
            he_q <= i_txf_empty & ~data_wr & ~o_tx_push;
        else
            he_q <= i_thr_empty & ~data_wr & ~o_tx_push & ~i_tx_xfer;
    end

    assign serial_line_status = {ferr_q,
                  he_q & i_shift_empty,
                  he_q,
                  fifo_q ? (i_rx_head.brk & ~i_rx_empty) : brk_q,
                  i_lsr_low};

    // inter-frame gap timer for the dma status timeout
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
        begin
            gap_cnt_q <= 18'h0_0000;
            gap_run_q <= 1'b0;
        end
        else if (i_frame_start)
        begin
            gap_cnt_q <= 18'h0_0000;
            gap_run_q <= 1'b0;
        end
        else if (i_frame_end)
        begin
            gap_cnt_q <= 18'h0_0000;
            gap_run_q <= 1'b1;
        end
        else if (gap_run_q)
        begin
            gap_cnt_q <= gap_cnt_q + 18'h0_0001;
            if (gap_cnt_q + 18'h0_0001 >= 18'(GAP_CYCLES))
                gap_run_q <= 1'b0;
        end
    end

    // sticky event bits, cleared by reading the pending register
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_b)
            pend_q <= 8'h00;
        else
        begin
            pend_q[2] <= (mode_q == ir_pkg::MODE_PIO ? o_rx_pop & i_rx_head.last
                         : gap_run_q && gap_cnt_q + 18'h0_0001 >= 18'(GAP_CYCLES))
                         | (pend_q[2] & ~pend_rd);
            pend_q[3] <= i_rx_overrun | (pend_q[3] & ~pend_rd);
            pend_q[5] <= i_tx_underrun | (pend_q[5] & ~pend_rd);
            pend_q[6] <= i_dma_tc | (pend_q[6] & ~pend_rd);
            pend_q[7] <= i_rx_eof | (pend_q[7] & ~pend_rd);
            pend_q[0] <= 1'b0;
            pend_q[1] <= 1'b0;
            pend_q[4] <= 1'b0;
        end
    end

    always_comb
    begin
        level = 8'h00;
        case (mode_q)
            ir_pkg::MODE_PIO:
            begin
                level[0] = i_rx_at_thresh;
                level[1] = i_tx_below_thresh;
            end
            ir_pkg::MODE_DMA:
                level[4] = i_stat_at_thresh;
            default:
            begin
                level[0] = i_rx_at_thresh;
                level[1] = he_q;
                level[2] = |serial_line_status[4:1];
                level[3] = |delta_q;
            end
        endcase
    end

    assign pend_all = (mode_q == ir_pkg::MODE_SIR) ? level : (level | pend_q);
    assign o_irq    = |(pend_all & ier_q);

    assign o_divisor   = {dlm_q, dll_q};
    assign o_line_ctrl = lcr_q;
    assign o_mode      = mode_q;
    assign o_fifo_en   = fifo_q;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    property p_brk_clear;
        lsr_rd && !brk_event ##1 1'b1 |-> !brk_q;
    endproperty
    a_brk_clear: assert property (p_brk_clear) else $error("break flag kept after read");

    property p_brk_push;
        brk_event |=> o_brk_push && o_brk_entry.data == 8'h00 ##1 !o_rx_enable;
    endproperty
    a_brk_push: assert property (p_brk_push) else $error("break char not pushed");

    property p_he_drop;
        data_wr |=> !he_q;
    endproperty
    a_he_drop: assert property (p_he_drop) else $error("holding empty kept on write");

    property p_transmitter_empty_flag;
        serial_line_status[`LSR_TRANSMITTER_EMPTY_FLAG] |-> he_q && i_shift_empty;
    endproperty
    a_transmitter_empty_flag: assert property (p_transmitter_empty_flag) else $error("transmitter empty wrong");

    property p_ferr_off;
        !fifo_q |=> !ferr_q;
    endproperty
    a_ferr_off: assert property (p_ferr_off) else $error("fifo error with fifo off");

    property p_msr_level;
        handshake_status[7:4] == ~$past(sync1_q[3:0]);
    endproperty
    a_msr_level: assert property (p_msr_level) else $error("modem level wrong");

    property p_push;
        data_wr |=> o_tx_push && o_tx_data == $past(wbyte) ##1 !o_tx_push;
    endproperty
    a_push: assert property (p_push) else $error("tx push wrong");

    property p_ier_zero;
        (ier_q & ~ier_mask) == 8'h00 || $changed(mode_q);
    endproperty
    a_ier_zero: assert property (p_ier_zero) else $error("write-zero bit set");

    property p_irq;
        ier_q == 8'h00 |-> !o_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_ack;
        acc |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

    c_break: cover property (brk_event ##[1:1000] o_rx_enable);
    c_tx_irq: cover property (mode_q == ir_pkg::MODE_PIO && o_irq && ier_q[1]);
    c_gap: cover property (pend_q[2] && mode_q == ir_pkg::MODE_DMA);

endmodule

// ===== hw/ir_params.svh
`ifndef IR_PARAMS_SVH
`define IR_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_DATA       6'h00
`define IDX_IER        6'h01
`define IDX_PEND       6'h02
`define IDX_LCR        6'h03
`define IDX_LSR        6'h05
`define IDX_MSR        6'h06
`define IDX_SCR        6'h07
`define IDX_MODE       6'h08

// field positions
`define LCR_DLAB       7
`define LSR_BRK        4
`define LSR_HE         5
`define LSR_TRANSMITTER_EMPTY_FLAG       6
`define LSR_FERR       7
`define MODE_FIFO      2

// writable interrupt-enable bits per mode
`define IER_MASK_SIR   8'h0F
`define IER_MASK_PIO   8'hAF
`define IER_MASK_DMA   8'h74

`define RESET_BYTE     8'h00
`define MARK_SAMPLES   2'h2
`define TICKS_PER_BIT  4'h8

// inter-frame gap timeout
`define GAP_TIME_US    1000
`define CLK_MHZ        200
`define GAP_CYCLES     (`GAP_TIME_US * `CLK_MHZ)

`endif

// ===== hw/ir_pkg.sv
package ir_pkg;

    typedef enum logic [1:0] {
        MODE_SIR,
        MODE_PIO,
        MODE_DMA
    } mode_e;

    typedef enum logic [1:0] {
        BRK_HUNT,
        BRK_HELD,
        BRK_MARK,
        BRK_START
    } brk_state_e;

    // one receive fifo entry with its error tags
    typedef struct packed {
        logic       last;
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } rx_entry_s;

endpackage
